// >>> core/srm_ctrl.sv
// Readout mode, flash and Bayer gain control with AHB-Lite register slave
module srm_ctrl
  import srm_pkg::*;
#(
  parameter int COLS       = 64,
  parameter int ROWS       = 32,
  parameter int HBLANK     = 8,
  parameter int VBLANK     = 8,
  parameter int INTEG_ROWS = 4
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        capture_req,
  output logic             pixel_clock_out,
  output logic             frame_valid_out,
  output logic             row_valid_out,
  output logic             flash_out,
  output logic      [9:0]  pixel_data_out,
  output logic      [6:0]  pixel_gain_out,
  output logic      [7:0]  pixel_gain_x8_out
);
  localparam logic [15:0] LINE_LAST = 16'(HBLANK + COLS - 1);
  localparam logic [15:0] HB        = 16'(HBLANK);
  localparam logic [15:0] NCOLS     = 16'(COLS);
  localparam logic [15:0] NROWS     = 16'(ROWS);
  localparam logic [15:0] VB_LAST   = 16'(VBLANK - 1);
  localparam logic [15:0] IN_LAST   = 16'(INTEG_ROWS - 1);

  // ************************************************************
  // AHB-Lite slave
  // ************************************************************
  logic [15:0] mode_pri_r, mode_sec_r;
  logic [6:0]  gain_r [4];
  logic        restart_r;
  logic        wr_pend_r;
  logic [7:0]  wr_idx_r;
  logic [31:0] hrdata_r;
  logic        hreadyout_r;

  wire         addr_ok  = hsel && hready && htrans[1];
  wire  [7:0]  a_idx    = haddr[9:2];
  wire         wr_pri   = wr_pend_r && wr_idx_r == IDX_MODE_PRI;
  wire         wr_sec   = wr_pend_r && wr_idx_r == IDX_MODE_SEC;
  wire         wr_rst   = wr_pend_r && wr_idx_r == IDX_RESTART && hwdata[RESTART_BIT];
  wire  [15:0] wdat16   = hwdata[15:0];
  // Reads use the stored value, so a read right after a write to the same word sees the old value
  wire  [31:0] rd_mux   = a_idx == IDX_MODE_PRI  ? {16'h0000, mode_pri_r} :
                          a_idx == IDX_MODE_SEC  ? {16'h0000, mode_sec_r} :
                          a_idx == IDX_RESTART   ? {31'h00000000, restart_r} :
                          a_idx == IDX_GAIN_G1   ? {25'h0000000, gain_r[0]} :
                          a_idx == IDX_GAIN_BLUE ? {25'h0000000, gain_r[1]} :
                          a_idx == IDX_GAIN_RED  ? {25'h0000000, gain_r[2]} :
                          a_idx == IDX_GAIN_G2   ? {25'h0000000, gain_r[3]} : 32'h00000000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r   <= 1'b0;
      wr_idx_r    <= 8'h00;
      hrdata_r    <= 32'h00000000;
      hreadyout_r <= 1'b0;
    end else begin
      wr_pend_r   <= addr_ok && hwrite;
      wr_idx_r    <= a_idx;
      hrdata_r    <= (addr_ok && !hwrite) ? rd_mux : 32'h00000000;
      hreadyout_r <= 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_pri_r <= MODE_PRI_RST;
      mode_sec_r <= MODE_SEC_RST;
    end else begin
      if (wr_pri) mode_pri_r <= wdat16;
      if (wr_sec) mode_sec_r <= wdat16;
    end
  end

  // Bayer order: green_first, blue, red, green_second
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_gain
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) gain_r[g] <= GAIN_RST;
        else if (wr_pend_r && wr_idx_r == IDX_GAIN_G1 + 8'(g)) gain_r[g] <= hwdata[6:0];
      end
    end
  endgenerate

  assign hrdata    = hrdata_r;
  assign hreadyout = hreadyout_r;
  assign hresp     = 1'b0;

  // ************************************************************
  // Capture request synchroniser and pixel clock
  // ************************************************************
  logic cap_s1_r, cap_s2_r, cap_s3_r, trig_pend_r, pclk_r;
  srm_state_e state_r, state_nxt;
  logic [15:0] pix_r, row_r;
  wire  pix_tick = pclk_r;
  wire  row_end  = pix_tick && pix_r == LINE_LAST;
  wire  cap_edge = cap_s2_r && !cap_s3_r;
  wire  snap     = mode_pri_r[PRI_SNAPSHOT];
  // Clearing snapshot while waiting must resume streaming, else the sequencer parks for good
  wire  trig_use = pix_tick && state_r == ST_WAIT && (trig_pend_r || restart_r || !snap);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cap_s1_r    <= 1'b0;
      cap_s2_r    <= 1'b0;
      cap_s3_r    <= 1'b0;
      trig_pend_r <= 1'b0;
      pclk_r      <= 1'b0;
    end else begin
      cap_s1_r    <= capture_req;
      cap_s2_r    <= cap_s1_r;
      cap_s3_r    <= cap_s2_r;
      trig_pend_r <= cap_edge || (trig_pend_r && !trig_use);
      pclk_r      <= !pclk_r;
    end
  end

  // ************************************************************
  // Skip and flip address mapping
  // ************************************************************
  wire [1:0] col_sh = mode_pri_r[PRI_COL_SKIP8] ? 2'd3 : mode_pri_r[PRI_COL_SKIP4] ? 2'd2 :
                      mode_sec_r[SEC_COL_PAIR] ? 2'd1 : 2'd0;
  wire [1:0] row_sh = mode_pri_r[PRI_ROW_SKIP8] ? 2'd3 : mode_pri_r[PRI_ROW_SKIP4] ? 2'd2 :
                      mode_sec_r[SEC_ROW_PAIR] ? 2'd1 : 2'd0;
  wire [15:0] out_cols = NCOLS >> col_sh;
  wire [15:0] out_rows = NROWS >> row_sh;
  wire [15:0] ocol     = pix_r - HB;
  wire [15:0] orow     = row_r + {15'h0000, mode_sec_r[SEC_FLIP_ROW]};
  wire [15:0] pcol     = (((ocol >> 1) << col_sh) << 1) | {15'h0000, ocol[0]};
  wire [15:0] prow_u   = (((orow >> 1) << row_sh) << 1) | {15'h0000, orow[0]};
  wire [15:0] prow_w   = prow_u % NROWS;
  wire [15:0] prow     = mode_sec_r[SEC_MIRROR] ? NROWS - 16'h0001 - prow_w : prow_w;
  wire        in_cols  = pix_r >= HB && ocol < out_cols;
  wire [1:0]  bay_idx  = {prow[0], prow[0] ^ pcol[0]};
  wire [6:0]  gsel     = gain_r[bay_idx];
  wire [7:0]  gain_lo  = 8'({1'b0, gsel[5:0]} << gsel[6]);
  wire [7:0]  gain_hi  = GAIN_HI_BASE + {2'b00, gsel[2:0], 3'b000};
  wire [7:0]  gain_x8  = (gsel[6] && gsel[5]) ? gain_hi : gain_lo;

  // ************************************************************
  // Frame sequencer
  // ************************************************************
  logic bad_pend_r, bad_frame_r;
  wire  st_last  = (state_r == ST_ACTIVE && row_r == out_rows - 16'h0001) ||
                   (state_r == ST_VBLANK && row_r == VB_LAST) ||
                   (state_r == ST_INTEG && row_r == IN_LAST);
  wire  rst_go   = pix_tick && restart_r && !snap;
  wire  geom_chg = (wr_pri && (wdat16[5:2] != mode_pri_r[5:2])) ||
                   (wr_sec && ({wdat16[15], wdat16[4:3]} != {mode_sec_r[15], mode_sec_r[4:3]}));
  wire  frm_go   = pix_tick && ((state_nxt == ST_ACTIVE && state_r != ST_ACTIVE) || rst_go);

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_WAIT:   if (trig_use) state_nxt = ST_INTEG;
      ST_INTEG:  if (row_end && st_last) state_nxt = ST_ACTIVE;
      ST_ACTIVE: if (row_end && st_last) state_nxt = ST_VBLANK;
      ST_VBLANK: if (row_end && st_last) state_nxt = snap ? ST_WAIT : ST_INTEG;
      default:   state_nxt = ST_WAIT;
    endcase
    if (rst_go) state_nxt = ST_ACTIVE;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= ST_INTEG;
      pix_r   <= 16'h0000;
      row_r   <= 16'h0000;
    end else if (pix_tick) begin
      state_r <= state_nxt;
      pix_r   <= (row_end || rst_go || trig_use) ? 16'h0000 : pix_r + 16'h0001;
      row_r   <= (rst_go || trig_use || (row_end && st_last)) ? 16'h0000 :
                 row_end ? row_r + 16'h0001 : row_r;
    end
  end

  // Set wins over consumption, so a write landing on the consuming tick is kept
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      restart_r   <= 1'b0;
      bad_pend_r  <= 1'b0;
      bad_frame_r <= 1'b0;
    end else begin
      restart_r   <= wr_rst || (restart_r && !pix_tick);
      bad_pend_r  <= geom_chg || (bad_pend_r && !frm_go);
      if (frm_go) bad_frame_r <= (bad_pend_r || rst_go) && !mode_sec_r[SEC_BAD_OUT];
    end
  end

  // ************************************************************
  // Qualifiers, flash and pixel outputs
  // ************************************************************
  wire lv_cont  = in_cols && state_r != ST_WAIT;
  wire fv_w     = state_r == ST_ACTIVE && !bad_frame_r;
  wire lv_frame = in_cols && fv_w;
  wire lv_xor   = lv_cont ^ fv_w;
  wire lv_sel   = mode_sec_r[SEC_ROW_XOR] ? lv_xor :
                  mode_sec_r[SEC_ROW_CONT] ? lv_cont : lv_frame;
  wire fl_time  = state_r == ST_INTEG && (mode_pri_r[PRI_FLASH_WID] || row_r == IN_LAST);
  wire fl_w     = mode_pri_r[PRI_FLASH_OVR] ? 1'b1 : (mode_pri_r[PRI_FLASH_EN] && fl_time);

  logic fv_r, lv_r, fl_r;
  logic [9:0] pd_r;
  logic [6:0] pg_r;
  logic [7:0] px8_r;
  // Outputs move only as the pixel clock falls, so they are settled at its rising edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fv_r  <= 1'b0;
      lv_r  <= 1'b0;
      fl_r  <= 1'b0;
      pd_r  <= 10'h000;
      pg_r  <= 7'h00;
      px8_r <= 8'h00;
    end else if (pix_tick) begin
      fv_r  <= fv_w;
      lv_r  <= lv_sel;
      fl_r  <= fl_w;
      pd_r  <= lv_frame ? {prow[4:0], pcol[4:0]} : 10'h000;
      pg_r  <= lv_frame ? gsel : 7'h00;
      px8_r <= lv_frame ? gain_x8 : 8'h00;
    end
  end

  assign pixel_clock_out   = pclk_r;
  assign frame_valid_out   = fv_r;
  assign row_valid_out     = lv_r;
  assign flash_out         = fl_r;
  assign pixel_data_out    = pd_r;
  assign pixel_gain_out    = pg_r;
  assign pixel_gain_x8_out = px8_r;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_restart_clear;
    restart_r && pix_tick && !wr_rst |=> !restart_r;
  endproperty
  a_restart_clear: assert property (p_restart_clear) else $error("restart bit did not self-clear");

  property p_restart_row0;
    rst_go |=> state_r == ST_ACTIVE && row_r == 16'h0000 ##1 bad_frame_r == !mode_sec_r[SEC_BAD_OUT];
  endproperty
  a_restart_row0: assert property (p_restart_row0) else $error("restart did not start a bad frame");

  property p_override;
    mode_pri_r[PRI_FLASH_OVR] && pix_tick && !wr_pri |=> flash_out;
  endproperty
  a_override: assert property (p_override) else $error("flash override not followed");

  property p_flash_off;
    !mode_pri_r[PRI_FLASH_EN] && !mode_pri_r[PRI_FLASH_OVR] && pix_tick && !wr_pri |=> !flash_out;
  endproperty
  a_flash_off: assert property (p_flash_off) else $error("flash without enable");

  property p_flash_short;
    flash_out && !mode_pri_r[PRI_FLASH_WID] && !mode_pri_r[PRI_FLASH_OVR] && mode_sec_r[10:9] == 2'b00
      |-> !row_valid_out;
  endproperty
  a_flash_short: assert property (p_flash_short) else $error("short flash overlaps row qualifier");

  property p_snap_wait;
    state_r == ST_WAIT && snap && !trig_pend_r && !restart_r && !cap_edge && !wr_rst |=> state_r == ST_WAIT;
  endproperty
  a_snap_wait: assert property (p_snap_wait) else $error("snapshot left wait without trigger");

  property p_bad_hidden;
    bad_frame_r && pix_tick |=> !frame_valid_out;
  endproperty
  a_bad_hidden: assert property (p_bad_hidden) else $error("bad frame reached frame qualifier");

  property p_pclk_sync;
    $changed(row_valid_out) || $changed(frame_valid_out) || $changed(flash_out) |-> !pixel_clock_out;
  endproperty
  a_pclk_sync: assert property (p_pclk_sync) else $error("qualifier moved off the falling pixel clock");

  property p_vblank_quiet;
    state_r == ST_VBLANK && mode_sec_r[10:9] == 2'b00 && pix_tick && !wr_sec |=> !row_valid_out;
  endproperty
  a_vblank_quiet: assert property (p_vblank_quiet) else $error("row qualifier in vertical blanking");

  property p_row_xor;
    mode_sec_r[SEC_ROW_XOR] && pix_tick && !wr_sec |=> row_valid_out == $past(lv_xor);
  endproperty
  a_row_xor: assert property (p_row_xor) else $error("xor row qualifier wrong");

  c_frame:   cover property (state_r == ST_ACTIVE && row_end && st_last);
  c_snap:    cover property (state_r == ST_WAIT ##[1:1000] state_r == ST_INTEG);
  c_flash:   cover property (flash_out && mode_pri_r[PRI_FLASH_EN]);
  c_restart: cover property (rst_go);
endmodule : srm_ctrl

// >>> core/srm_pkg.sv
// Constants and types of the sensor readout mode and gain control block
// Overview of operation
// - Primary mode bit 2 reads every fourth column group, bit 4 every eighth.
// - Primary mode bit 3 reads every fourth row group, bit 5 every eighth.
// - Snapshot bit 8 waits for capture pin or restart write before a frame.
// - Flash enable bit 9 drives flash during integration, width set by bit 10; clear means none.
// - Flash width bit 10: zero gives one row before row qualifier, one whole interval.
// - Override bit 11 drives flash from its own value; host keeps enable low.
// - First frame after skip or mirror change is suppressed unless secondary bit 0.
// - Secondary bit 3 outputs two columns then omits two, across the row.
// - Secondary bit 4 outputs two rows then omits two, down the frame.
// - Secondary bit 7 starts readout one row later, alternate colour pair first.
// - Secondary bit 9 keeps row qualifier pulsing through vertical blanking.
// - Secondary bit 10 makes row qualifier continuous row XOR frame qualifier.
// - Secondary bit 15 reads bottom row to top, image upside down.
// - Gain up to eight is (bit6 plus one) times bits 5..0 times 0.125.
// - Bits 6 and 5 both set give gain 8.0 plus bits 2..0.
// - Four seven-bit Bayer gain fields, each resetting to unity 0x08.
// - Restart bit 0 self-clears; with snapshot clear it abandons frame, restarts first row, marks bad unless secondary bit 0.
package srm_pkg;
  // ************************************************************
  // Register indices, byte address is four times the index
  // ************************************************************
  localparam logic [7:0]  IDX_RESTART   = 8'h0B;
  localparam logic [7:0]  IDX_MODE_PRI  = 8'h1E;
  localparam logic [7:0]  IDX_MODE_SEC  = 8'h20;
  localparam logic [7:0]  IDX_GAIN_G1   = 8'h2B;
  localparam logic [7:0]  IDX_GAIN_BLUE = 8'h2C;
  localparam logic [7:0]  IDX_GAIN_RED  = 8'h2D;
  localparam logic [7:0]  IDX_GAIN_G2   = 8'h2E;
  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [15:0] MODE_PRI_RST  = 16'h8000;
  localparam logic [15:0] MODE_SEC_RST  = 16'h1104;
  localparam logic [6:0]  GAIN_RST      = 7'h08;
  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int PRI_COL_SKIP4 = 2;
  localparam int PRI_ROW_SKIP4 = 3;
  localparam int PRI_COL_SKIP8 = 4;
  localparam int PRI_ROW_SKIP8 = 5;
  localparam int PRI_SNAPSHOT  = 8;
  localparam int PRI_FLASH_EN  = 9;
  localparam int PRI_FLASH_WID = 10;
  localparam int PRI_FLASH_OVR = 11;
  localparam int SEC_BAD_OUT   = 0;
  localparam int SEC_COL_PAIR  = 3;
  localparam int SEC_ROW_PAIR  = 4;
  localparam int SEC_FLIP_ROW  = 7;
  localparam int SEC_ROW_CONT  = 9;
  localparam int SEC_ROW_XOR   = 10;
  localparam int SEC_MIRROR    = 15;
  localparam int RESTART_BIT   = 0;
  // Gain is carried in eighths: 0.125 is one step, 8.0 is 64 steps
  localparam logic [7:0]  GAIN_HI_BASE  = 8'h40;
  // ************************************************************
  // Frame sequencer states
  // ************************************************************
  typedef enum logic [3:0] {
    ST_WAIT   = 4'b0001,
    ST_INTEG  = 4'b0010,
    ST_ACTIVE = 4'b0100,
    ST_VBLANK = 4'b1000
  } srm_state_e;
endpackage : srm_pkg

// >>> verif/sensor_readout_mode_gain_ctrl_test.sv
// Self-checking bench: registers, frame shaping, flash, gain and snapshot
module sensor_readout_mode_gain_ctrl_test
  import srm_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  localparam int COLS = 32;
  localparam int ROWS = 32;
  localparam int HBLANK = 2;
  localparam int VBLANK = 2;
  localparam int INTEG = 2;
  localparam int ROW_T = HBLANK + COLS;
  localparam int FRAME = 2 * ROW_T * (ROWS + VBLANK + INTEG);
  localparam logic [7:0]  IDX_T [8] = '{IDX_RESTART, IDX_MODE_PRI, IDX_MODE_SEC, IDX_GAIN_G1, IDX_GAIN_BLUE,
                                        IDX_GAIN_RED, IDX_GAIN_G2, 8'h3F};
  localparam logic [31:0] RST_T [8] = '{32'h0, 32'h8000, 32'h1104, 32'h8, 32'h8, 32'h8, 32'h8, 32'h0};
  // Reserved bits kept at their defaults in every mode value
  localparam logic [31:0] PRI_T [8] = '{32'h8004, 32'h8010, 32'h8008, 32'h8020, 32'h8000, 32'h8000, 32'h8000,
                                        32'h8000};
  localparam logic [31:0] SEC_T [8] = '{32'h1104, 32'h1104, 32'h1104, 32'h1104, 32'h110C, 32'h1114, 32'h1184,
                                        32'h9104};
  localparam logic [31:0] PIX_T [8] = '{32'h100, 32'h80, 32'h100, 32'h80, 32'h200, 32'h200, 32'h400, 32'h400};
  localparam logic [31:0] FST_T [8] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h20, 32'h3E0};
  localparam logic [31:0] THD_T [8] = '{32'h8, 32'h10, 32'h2, 32'h2, 32'h4, 32'h2, 32'h22, 32'h3E2};
  localparam logic [31:0] RW2_T [8] = '{32'h40, 32'h40, 32'h100, 32'h200, 32'h40, 32'h80, 32'h60, 32'h3A0};
  localparam logic [31:0] GC_T [5] = '{32'h20, 32'h51, 32'h60, 32'h61, 32'h67};
  localparam logic [31:0] GX_T [5] = '{32'h20, 32'h22, 32'h40, 32'h48, 32'h78};
  logic        hclk, hresetn, hsel, hwrite, capture_req, hreadyout, hresp;
  logic        pixel_clock_out, frame_valid_out, row_valid_out, flash_out;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [9:0]  pixel_data_out, first_data, third_data, row2_data;
  logic [6:0]  pixel_gain_out, first_gc;
  logic [7:0]  pixel_gain_x8_out, first_gx8;
  int          frames, last_pix, last_flash, last_vb, step_err, n;
  int          n_errors = 0;
  int          n_tests = 0;
  srm_ctrl #(.COLS(COLS), .ROWS(ROWS), .HBLANK(HBLANK), .VBLANK(VBLANK), .INTEG_ROWS(INTEG)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .capture_req(capture_req), .pixel_clock_out(pixel_clock_out),
    .frame_valid_out(frame_valid_out), .row_valid_out(row_valid_out), .flash_out(flash_out),
    .pixel_data_out(pixel_data_out), .pixel_gain_out(pixel_gain_out), .pixel_gain_x8_out(pixel_gain_x8_out));
  srm_capture cap (
    .hclk(hclk), .pixel_clock_out(pixel_clock_out), .frame_valid_out(frame_valid_out),
    .row_valid_out(row_valid_out), .flash_out(flash_out), .pixel_data_out(pixel_data_out),
    .pixel_gain_x8_out(pixel_gain_x8_out), .frames(frames), .last_pix(last_pix), .last_flash(last_flash),
    .last_vb(last_vb), .step_err(step_err), .first_data(first_data), .third_data(third_data),
    .row2_data(row2_data), .first_gx8(first_gx8), .pixel_gain_out(pixel_gain_out), .first_gc(first_gc));
  // ************************************************************
  // Bus and bookkeeping tasks
  // ************************************************************
  function automatic logic [31:0] ba(input logic [7:0] idx);
    return {22'h0, idx, 2'b00};
  endfunction : ba
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic ahb_write(input logic [31:0] a, input logic [31:0] d);
    haddr <= a;
    hwrite <= 1'b1;
    htrans <= 2'b10;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask : ahb_write
  task automatic ahb_read(input logic [31:0] a, output logic [31:0] d);
    haddr <= a;
    hwrite <= 1'b0;
    htrans <= 2'b10;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    d = hrdata;
    check("hresp", {31'h0, hresp}, 32'h0);
  endtask : ahb_read
  // Returns just after a frame ends, so the next write lands in blanking
  task automatic wait_frames(input int k);
    int f;
    repeat (k) begin
      f = frames;
      while (frames == f) @(negedge hclk);
    end
    @(posedge hclk);
  endtask : wait_frames
  task automatic fv_window(output int cnt);
    cnt = 0;
    repeat (2 * ROWS * ROW_T) begin
      @(negedge hclk);
      cnt += frame_valid_out;
    end
    @(posedge hclk);
  endtask : fv_window
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  initial begin
    #1ms;
    n_errors++;
    give_verdict();
  end
  // ************************************************************
  // Test sequence
  // ************************************************************
  initial begin
    hresetn = 1'b0;
    hsel = 1'b1;
    htrans = 2'b00;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    capture_req = 1'b0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 8; i++) begin
      ahb_read(ba(IDX_T[i]), rd);
      check("reset value", rd, RST_T[i]);
    end
    ahb_write(ba(8'h3F), 32'hFFFF);
    ahb_read(ba(8'h3F), rd);
    check("unmapped", rd, 32'h0);
    ahb_write(ba(IDX_GAIN_G2), 32'hFF);
    ahb_read(ba(IDX_GAIN_G2), rd);
    check("gain width", rd, 32'h7F);
    wait_frames(2);
    check("pixels", last_pix, COLS * ROWS);
    check("first pixel", first_data, 10'h0);
    check("unity gain", first_gx8, 8'h08);
    check("no flash", last_flash, 0);
    check("blank rows", last_vb, 0);
    for (int i = 0; i < 8; i++) begin
      ahb_write(ba(IDX_MODE_PRI), PRI_T[i]);
      ahb_write(ba(IDX_MODE_SEC), SEC_T[i]);
      wait_frames(1);
      check("skip pixels", last_pix, PIX_T[i]);
      check("first", first_data, FST_T[i]);
      check("third", third_data, THD_T[i]);
      check("row two", row2_data, RW2_T[i]);
    end
    ahb_write(ba(IDX_MODE_SEC), 32'h1104);
    wait_frames(1);
    for (int i = 0; i < 5; i++) begin
      ahb_write(ba(IDX_GAIN_G1), GC_T[i]);
      wait_frames(1);
      check("gain", first_gx8, GX_T[i]);
      check("gain code", first_gc, GC_T[i]);
    end
    ahb_write(ba(IDX_MODE_PRI), 32'h8200);
    wait_frames(1);
    check("short flash", last_flash, ROW_T);
    ahb_write(ba(IDX_MODE_PRI), 32'h8600);
    wait_frames(1);
    check("long flash", last_flash, INTEG * ROW_T);
    ahb_write(ba(IDX_MODE_PRI), 32'h8800);
    repeat (6) @(posedge hclk);
    check("override high", flash_out, 1'b1);
    ahb_write(ba(IDX_MODE_PRI), 32'h8000);
    repeat (6) @(posedge hclk);
    check("override low", flash_out, 1'b0);
    wait_frames(1);
    ahb_write(ba(IDX_MODE_SEC), 32'h1304);
    wait_frames(1);
    check("blank pulses", last_vb != 0, 1'b1);
    ahb_write(ba(IDX_MODE_SEC), 32'h1504);
    wait_frames(1);
    check("xor row", last_pix >= (ROWS - 1) * HBLANK && last_pix <= ROWS * HBLANK, 1'b1);
    ahb_write(ba(IDX_MODE_SEC), 32'h1104);
    wait_frames(1);
    ahb_write(ba(IDX_RESTART), 32'h1);
    repeat (4) @(posedge hclk);
    ahb_read(ba(IDX_RESTART), rd);
    check("restart clear", rd, 32'h0);
    fv_window(n);
    check("bad hidden", n, 0);
    fv_window(n);
    check("next frame shown", n > ROWS * ROW_T, 1'b1);
    wait_frames(1);
    ahb_write(ba(IDX_MODE_SEC), 32'h1105);
    ahb_write(ba(IDX_RESTART), 32'h1);
    fv_window(n);
    check("bad shown", n > ROWS * ROW_T, 1'b1);
    wait_frames(1);
    ahb_write(ba(IDX_MODE_SEC), 32'h1104);
    ahb_write(ba(IDX_MODE_PRI), 32'h8100);
    n = frames;
    repeat (2 * FRAME) @(posedge hclk);
    check("snapshot idle", frames, n);
    capture_req <= 1'b1;
    repeat (4) @(posedge hclk);
    capture_req <= 1'b0;
    repeat (2 * FRAME) @(posedge hclk);
    check("one frame", frames, n + 1);
    ahb_write(ba(IDX_MODE_PRI), 32'h8000);
    wait_frames(1);
    check("stream resumes", last_pix, COLS * ROWS);
    check("pixel clock steps", step_err, 0);
    give_verdict();
  end
endmodule : sensor_readout_mode_gain_ctrl_test

// >>> verif/srm_capture.sv
// Capture side model of the pixel link, keeping per-frame statistics
module srm_capture
  import srm_pkg::*;
(
  input  wire logic       hclk,
  input  wire logic       pixel_clock_out,
  input  wire logic       frame_valid_out,
  input  wire logic       row_valid_out,
  input  wire logic       flash_out,
  input  wire logic [9:0] pixel_data_out,
  input  wire logic [7:0] pixel_gain_x8_out,
  input  wire logic [6:0] pixel_gain_out,
  output int              frames,
  output int              last_pix,
  output int              last_flash,
  output int              last_vb,
  output int              step_err,
  output logic      [9:0] first_data,
  output logic      [9:0] third_data,
  output logic      [9:0] row2_data,
  output logic      [7:0] first_gx8,
  output logic      [6:0] first_gc
);
  timeunit 1ns;
  timeprecision 1ps;
  int         pix_c = 0;
  int         fl_c = 0;
  int         vb_c = 0;
  int         row_c = 0;
  int         col_c = 0;
  logic       fv_q = 1'b0;
  logic       rv_q = 1'b0;
  logic       pclk_q;
  logic [2:0] outs_q;
  initial begin
    frames = 0;
    last_pix = 0;
    last_flash = 0;
    last_vb = 0;
    step_err = 0;
  end
  // ************************************************************
  // Sampling on the rising pixel clock, like the real receiver
  // ************************************************************
  always @(posedge pixel_clock_out) begin
    if (frame_valid_out && !fv_q) begin
      last_flash = fl_c;
      last_vb = vb_c;
      fl_c = 0;
      vb_c = 0;
      pix_c = 0;
      row_c = 0;
    end
    fl_c += flash_out;
    if (!frame_valid_out && row_valid_out && !rv_q) vb_c++;
    if (frame_valid_out && row_valid_out) begin
      if (!rv_q) begin
        row_c++;
        col_c = 0;
      end
      if (row_c == 1 && col_c == 0) first_data = pixel_data_out;
      if (row_c == 1 && col_c == 0) first_gx8 = pixel_gain_x8_out;
      if (row_c == 1 && col_c == 0) first_gc = pixel_gain_out;
      if (row_c == 1 && col_c == 2) third_data = pixel_data_out;
      if (row_c == 3 && col_c == 0) row2_data = pixel_data_out;
      col_c++;
      pix_c++;
    end
    // Frame is only counted once complete, so hidden frames never count
    if (!frame_valid_out && fv_q) begin
      last_pix = pix_c;
      frames++;
    end
    fv_q = frame_valid_out;
    rv_q = row_valid_out;
  end
  // Qualifiers and flash may move only where the pixel clock falls
  always @(negedge hclk) begin
    if ({frame_valid_out, row_valid_out, flash_out} != outs_q && !(pclk_q && !pixel_clock_out)) step_err++;
    outs_q = {frame_valid_out, row_valid_out, flash_out};
    pclk_q = pixel_clock_out;
  end
endmodule : srm_capture
